/* File: common/intc_pkg.sv */
// Constants for the interrupt and trap priority resolver.
// Assumes a single 20 MHz system clock and an APB register port.
package intc_pkg;

  // ***************************************************************
  // Sources and vectors
  // ***************************************************************
  localparam int NUM_SRC = 54;
  localparam int PRIO_W = 3;
  localparam int NIB_W = 4;
  localparam int NIB_PER_REG = 4;
  localparam int NUM_PRIO_REGS = 14;
  localparam logic [5:0] VEC_OFFSET = 6'h08;
  localparam logic [53:0] SRC_IMPL_MASK = 54'h0400_0381_FFFF;
  localparam logic [53:0] UART_B_MASK = 54'h0000_0300_0000;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [3:0] BLOCK_ALL_LEVEL = 4'h7;
  localparam logic [23:0] RESET_ADDR = 24'h000000;

  // ***************************************************************
  // Traps
  // ***************************************************************
  localparam logic [3:0] MATH_TRAP_LEVEL = 4'hB;
  localparam logic [3:0] ADDR_TRAP_LEVEL = 4'hC;
  localparam logic [5:0] MATH_TRAP_VEC = 6'h03;
  localparam logic [5:0] ADDR_TRAP_VEC = 6'h04;

  // ***************************************************************
  // Register map
  // ***************************************************************
  localparam logic [11:0] PRIO_END_ADDR = 12'h038;
  localparam logic [11:0] CTRL_ADDR = 12'h040;
  localparam logic [11:0] TRAP_STAT_ADDR = 12'h044;
  localparam logic [11:0] RST_CAUSE_ADDR = 12'h048;
  localparam logic [11:0] SEL_STAT_ADDR = 12'h04C;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int CTRL_OVF31_EN = 0;
  localparam int CTRL_OVF39_EN = 1;
  localparam int CAUSE_WDT = 0;
  localparam int CAUSE_UNINIT = 1;
  localparam int CAUSE_ILLEGAL = 2;
  localparam int CAUSE_BROWNOUT = 3;
  localparam int CAUSE_LOCKOUT = 4;
  localparam int CAUSE_W = 5;

endpackage : intc_pkg

/* File: core/priority_pick.sv */
// Picks the highest user priority among candidate sources.
// Assumes candidates already exclude disabled and reserved sources.
`timescale 1ns/1ps
`default_nettype none
module priority_pick #(
  parameter int NUM = 54
) (
  input wire logic [NUM-1:0] cand,
  input wire logic [NUM*3-1:0] prio_flat,
  output logic found,
  output logic [5:0] idx,
  output logic [2:0] level
);

  // ***************************************************************
  // Search
  // ***************************************************************
  // Walking from the top index down with >= lets the lower number win ties
  always_comb begin
    found = 1'b0;
    idx = 6'h00;
    level = 3'h0;
    for (int i = NUM - 1; i >= 0; i--) begin
      if (cand[i] && (prio_flat[i*3 +: 3] >= level)) begin
        found = 1'b1;
        idx = 6'(i);
        level = prio_flat[i*3 +: 3];
      end
    end
  end

endmodule : priority_pick
`default_nettype wire

/* File: core/interrupt_trap_priority_resolver.sv */
// Interrupt and trap priority resolver with APB register port.
// Assumes peripherals, trap detectors and the core share ref_clk.
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module interrupt_trap_priority_resolver #(
  parameter bit HAS_UART_B = 1'b1
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [53:0] irq_pending,
  input wire logic [3:0] cpu_priority_level,
  output logic irq_req,
  output logic [5:0] irq_vector,
  output logic [2:0] irq_level,
  input wire logic insn_done,
  input wire logic trap_ack,
  input wire logic trap_exit,
  input wire logic div_by_zero,
  input wire logic shift_too_far,
  input wire logic acc_ovf31,
  input wire logic guard_bits_used,
  input wire logic acc_ovf39,
  input wire logic saturation_on,
  input wire logic misaligned_access,
  input wire logic unimpl_data_access,
  input wire logic unimpl_prog_access,
  input wire logic vector_space_fetch,
  input wire logic mac_x_hits_y,
  input wire logic mac_y_hits_x,
  input wire logic invalid_vector_addr,
  input wire logic literal_jump_unimpl,
  input wire logic pc_exec_unimpl,
  output logic div_abort,
  output logic trap_req,
  output logic [5:0] trap_vector,
  output logic [3:0] trap_level,
  output logic trap_level_top_bit,
  input wire logic wdt_timeout,
  input wire logic uninit_w_pointer,
  input wire logic illegal_opcode_exec,
  input wire logic insn_flushed,
  input wire logic brownout_reset,
  output logic reset_req,
  output logic [23:0] reset_vector_addr
);

  // ***************************************************************
  // Register port decode
  // ***************************************************************
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pwrite;
  wire prio_sel = (paddr < intc_pkg::PRIO_END_ADDR) && (paddr[1:0] == 2'h0);
  wire ctrl_sel = (paddr == intc_pkg::CTRL_ADDR);
  wire tstat_sel = (paddr == intc_pkg::TRAP_STAT_ADDR);
  wire cause_sel = (paddr == intc_pkg::RST_CAUSE_ADDR);
  wire selst_sel = (paddr == intc_pkg::SEL_STAT_ADDR);
  wire mapped = prio_sel || ctrl_sel || tstat_sel || cause_sel || selst_sel;
  wire [3:0] prio_idx = paddr[5:2];

  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic slverr_q;

  assign pready = penable;
  assign prdata = prdata_q;
  assign pslverr = slverr_q;

  // ***************************************************************
  // Priority fields
  // ***************************************************************
  wire [53:0] impl_mask = HAS_UART_B ? intc_pkg::SRC_IMPL_MASK
                                     : (intc_pkg::SRC_IMPL_MASK & ~intc_pkg::UART_B_MASK);
  logic [2:0] prio_q [intc_pkg::NUM_SRC];
  logic [intc_pkg::NUM_SRC*3-1:0] prio_flat;
  logic [intc_pkg::NUM_PRIO_REGS*16-1:0] prio_words;
  logic [53:0] cand;

  for (genvar s = 0; s < intc_pkg::NUM_SRC; s++) begin : g_src
    wire wr_hit = apb_wr && prio_sel && (prio_idx == 4'(s / intc_pkg::NIB_PER_REG));
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        prio_q[s] <= intc_pkg::PRIO_RESET;
      end else if (wr_hit) begin
        prio_q[s] <= pwdata[(s % intc_pkg::NIB_PER_REG)*intc_pkg::NIB_W +: 3];
      end
    end
    assign prio_flat[s*3 +: 3] = prio_q[s];
    assign prio_words[s*4 +: 4] = {1'b0, prio_q[s]};
    // Reserved numbers and zero priority never compete
    assign cand[s] = irq_pending[s] && impl_mask[s] && (prio_q[s] != 3'h0);
  end
  assign prio_words[intc_pkg::NUM_PRIO_REGS*16-1:intc_pkg::NUM_SRC*4] = '0;

  // ***************************************************************
  // Interrupt selection
  // ***************************************************************
  logic sel_found;
  logic [5:0] sel_idx;
  logic [2:0] sel_level;
  logic trap_busy_q;

  // Highest value wins, natural order breaks ties
  priority_pick #(
    .NUM(intc_pkg::NUM_SRC)
  ) u_pick (
    .cand(cand),
    .prio_flat(prio_flat),
    .found(sel_found),
    .idx(sel_idx),
    .level(sel_level)
  );

  wire block_all = !trap_busy_q && (cpu_priority_level == intc_pkg::BLOCK_ALL_LEVEL);
  wire beats_cpu = {1'b0, sel_level} > cpu_priority_level;
  wire irq_go = sel_found && beats_cpu && !block_all;
  wire [5:0] sel_vec = sel_idx + intc_pkg::VEC_OFFSET;

  logic irq_req_q;
  logic [5:0] irq_vector_q;
  logic [2:0] irq_level_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      irq_req_q <= 1'b0;
      irq_vector_q <= 6'h00;
      irq_level_q <= 3'h0;
    end else begin
      irq_req_q <= irq_go;
      irq_vector_q <= irq_go ? sel_vec : irq_vector_q;
      irq_level_q <= irq_go ? sel_level : irq_level_q;
    end
  end
  assign irq_req = irq_req_q;
  assign irq_vector = irq_vector_q;
  assign irq_level = irq_level_q;

  // ***************************************************************
  // Trap detection
  // ***************************************************************
  logic [1:0] ctrl_q;
  wire ovf31_trap = ctrl_q[intc_pkg::CTRL_OVF31_EN] && acc_ovf31 && !guard_bits_used;
  wire ovf39_trap = ctrl_q[intc_pkg::CTRL_OVF39_EN] && acc_ovf39 && !saturation_on;
  wire math_cond = div_by_zero || shift_too_far || ovf31_trap || ovf39_trap;
  wire data_bad = misaligned_access || unimpl_data_access || mac_x_hits_y
                  || mac_y_hits_x;
  wire prog_bad = unimpl_prog_access || vector_space_fetch || literal_jump_unimpl
                  || pc_exec_unimpl;
  wire addr_cond = data_bad || prog_bad || invalid_vector_addr;
  wire lockout = math_cond && addr_cond;

  assign div_abort = div_by_zero;

  logic math_pend_q;
  logic addr_pend_q;
  logic trap_req_q;
  logic [5:0] trap_vector_q;
  logic [3:0] trap_level_q;

  // Serving the higher trap first; ack clears only the one offered
  wire ack_addr = trap_ack && trap_req_q && (trap_level_q == intc_pkg::ADDR_TRAP_LEVEL);
  wire ack_math = trap_ack && trap_req_q && (trap_level_q == intc_pkg::MATH_TRAP_LEVEL);
  wire trap_go = (math_pend_q || addr_pend_q) && insn_done && !trap_req_q;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      math_pend_q <= 1'b0;
      addr_pend_q <= 1'b0;
    end else begin
      // A new condition in the ack cycle survives the clear
      math_pend_q <= (math_cond && !lockout) || (math_pend_q && !ack_math);
      addr_pend_q <= (addr_cond && !lockout) || (addr_pend_q && !ack_addr);
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trap_req_q <= 1'b0;
      trap_vector_q <= 6'h00;
      trap_level_q <= 4'h0;
    end else if (trap_go) begin
      trap_req_q <= 1'b1;
      trap_vector_q <= addr_pend_q ? intc_pkg::ADDR_TRAP_VEC : intc_pkg::MATH_TRAP_VEC;
      trap_level_q <= addr_pend_q ? intc_pkg::ADDR_TRAP_LEVEL
                                  : intc_pkg::MATH_TRAP_LEVEL;
    end else if (trap_ack) begin
      trap_req_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      trap_busy_q <= 1'b0;
    end else if (trap_ack && trap_req_q) begin
      trap_busy_q <= 1'b1;
    end else if (trap_exit) begin
      trap_busy_q <= 1'b0;
    end
  end
  assign trap_req = trap_req_q;
  assign trap_vector = trap_vector_q;
  assign trap_level = trap_level_q;
  assign trap_level_top_bit = trap_busy_q;

  // ***************************************************************
  // Reset sources
  // ***************************************************************
  wire illegal_hit = illegal_opcode_exec && !insn_flushed;
  wire [intc_pkg::CAUSE_W-1:0] cause_now = {lockout, brownout_reset, illegal_hit,
                                             uninit_w_pointer, wdt_timeout};
  logic reset_req_q;
  logic [intc_pkg::CAUSE_W-1:0] cause_q;
  wire cause_clr = apb_wr && cause_sel;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      reset_req_q <= 1'b0;
      cause_q <= '0;
    end else begin
      reset_req_q <= |cause_now;
      cause_q <= cause_now | (cause_q & ~(cause_clr ? pwdata[intc_pkg::CAUSE_W-1:0] : '0));
    end
  end
  assign reset_req = reset_req_q;
  assign reset_vector_addr = intc_pkg::RESET_ADDR;

  // ***************************************************************
  // Register write and read
  // ***************************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= intc_pkg::CTRL_RESET;
    end else if (apb_wr && ctrl_sel) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  always_comb begin
    prdata_d = 32'h0000_0000;
    if (prio_sel) begin
      prdata_d = {16'h0000, prio_words[prio_idx*16 +: 16]};
    end else if (ctrl_sel) begin
      prdata_d = {30'h0000_0000, ctrl_q};
    end else if (tstat_sel) begin
      prdata_d = {29'h0000_0000, trap_busy_q, addr_pend_q, math_pend_q};
    end else if (cause_sel) begin
      prdata_d = {27'h0000_0000, cause_q};
    end else if (selst_sel) begin
      prdata_d = {22'h00_0000, irq_req_q, irq_level_q, irq_vector_q};
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (apb_setup) begin
      prdata_q <= pwrite ? 32'h0000_0000 : prdata_d;
      slverr_q <= !mapped;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  vector_offset_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    irq_req_q |-> (irq_vector_q == $past(sel_idx) + intc_pkg::VEC_OFFSET))
    else $error("irq vector is not number plus eight");

  zero_prio_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    irq_req_q |-> (irq_level_q != 3'h0))
    else $error("zero priority source interrupted");

  strict_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    irq_req_q |-> ({1'b0, irq_level_q} > $past(cpu_priority_level)))
    else $error("interrupt not above cpu level");

  block_all_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (!trap_busy_q && cpu_priority_level == 4'h7) |=> !irq_req_q)
    else $error("interrupt taken at level seven");

  reserved_src_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    irq_req_q |-> impl_mask[irq_vector_q - intc_pkg::VEC_OFFSET])
    else $error("reserved source selected");

  lockout_reset_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (math_cond && addr_cond) |=> reset_req_q && !$rose(math_pend_q))
    else $error("simultaneous traps did not reset");

  flushed_opcode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (illegal_opcode_exec && insn_flushed && !wdt_timeout && !uninit_w_pointer
     && !brownout_reset && !lockout) |=> !reset_req_q)
    else $error("flushed opcode caused reset");

  trap_waits_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    $rose(trap_req_q) |-> $past(insn_done))
    else $error("trap offered before instruction end");

  trap_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    trap_req_q |-> trap_level_q[3])
    else $error("trap level below eight");

  div_abort_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (div_by_zero && !addr_cond) |=> math_pend_q)
    else $error("divide by zero not pended");

endmodule : interrupt_trap_priority_resolver
`default_nettype wire

/* File: verification/core_side_model.sv */
// Behavioural processor core that faces the resolver: holds the CPU level,
// flags instruction completion, accepts traps and returns from them.
// Assumes one shared ref_clk and the active-low asynchronous nrst.
`timescale 1ns/1ps
`default_nettype none
module core_side_model (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic trap_req,
  input wire logic [3:0] trap_level,
  input wire logic [3:0] base_level,
  input wire logic [3:0] ack_wait,
  input wire logic stall,
  input wire logic exit_go,
  output logic [3:0] cpu_priority_level,
  output logic insn_done,
  output logic trap_ack,
  output logic trap_exit
);
  // ***********************************************
  // Level and completion
  // ***********************************************
  logic [3:0] wait_q;
  logic [3:0] held_q;
  logic in_trap_q;

  assign insn_done = !stall;
  assign cpu_priority_level = in_trap_q ? held_q : base_level;

  // ***********************************************
  // Trap acceptance, prompt or after ack_wait cycles
  // ***********************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= 4'h0;
      held_q <= 4'h0;
      in_trap_q <= 1'b0;
      trap_ack <= 1'b0;
      trap_exit <= 1'b0;
    end else begin
      trap_ack <= 1'b0;
      trap_exit <= 1'b0;
      if (trap_req && !trap_ack && !in_trap_q) begin
        if (wait_q == ack_wait) begin
          trap_ack <= 1'b1;
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
      if (trap_ack) begin
        in_trap_q <= 1'b1;
        held_q <= trap_level;
      end
      if (exit_go && in_trap_q) begin
        trap_exit <= 1'b1;
        in_trap_q <= 1'b0;
      end
    end
  end
endmodule : core_side_model
`default_nettype wire

/* File: verification/interrupt_trap_priority_resolver_tb_top.sv */
// Self-checking bench for the interrupt and trap priority resolver.
// Assumes core_side_model stands in for the processor core.
`timescale 1ns/1ps
`default_nettype none
module interrupt_trap_priority_resolver_tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err, irq_req, div_abort, trap_req, trap_level_top_bit, reset_req;
  logic [53:0] irq_pending = 54'h0;
  logic [3:0] cpu_priority_level, trap_level;
  logic [3:0] base_level = 4'h0, ack_wait = 4'h0;
  logic [5:0] irq_vector, trap_vector;
  logic [2:0] irq_level;
  logic [23:0] reset_vector_addr;
  logic insn_done, trap_ack, trap_exit;
  logic irq_req_b;
  logic stall = 1'b0, exit_go = 1'b0, guard = 1'b0, sat = 1'b0;
  logic [12:0] det = 13'h0;
  logic [4:0] rc = 5'h0;
  logic [2:0] pr [56] = '{default: 3'h4};
  int failures = 0;
  int cmp_count = 0;

  always #25 ref_clk = ~ref_clk;

  interrupt_trap_priority_resolver DUT (
    .ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .irq_pending, .cpu_priority_level, .irq_req, .irq_vector, .irq_level,
    .insn_done, .trap_ack, .trap_exit, .div_by_zero(det[0]), .shift_too_far(det[1]),
    .acc_ovf31(det[2]), .guard_bits_used(guard), .acc_ovf39(det[3]), .saturation_on(sat),
    .misaligned_access(det[4]), .unimpl_data_access(det[5]), .unimpl_prog_access(det[6]),
    .vector_space_fetch(det[7]), .mac_x_hits_y(det[8]), .mac_y_hits_x(det[9]),
    .invalid_vector_addr(det[10]), .literal_jump_unimpl(det[11]), .pc_exec_unimpl(det[12]),
    .div_abort, .trap_req, .trap_vector, .trap_level, .trap_level_top_bit,
    .wdt_timeout(rc[0]), .uninit_w_pointer(rc[1]), .illegal_opcode_exec(rc[2]),
    .insn_flushed(rc[3]), .brownout_reset(rc[4]), .reset_req, .reset_vector_addr
  );

  core_side_model core (
    .ref_clk, .nrst, .trap_req, .trap_level, .base_level, .ack_wait, .stall, .exit_go,
    .cpu_priority_level, .insn_done, .trap_ack, .trap_exit
  );

  // Variant without the second UART: its two numbers must stay reserved
  interrupt_trap_priority_resolver #(.HAS_UART_B(1'b0)) dut_b (
    .ref_clk, .nrst, .psel(1'b0), .penable(1'b0), .pwrite(1'b0), .paddr(12'h000),
    .pwdata(32'h0000_0000), .prdata(), .pready(), .pslverr(), .irq_pending,
    .cpu_priority_level, .irq_req(irq_req_b), .irq_vector(), .irq_level(), .insn_done,
    .trap_ack(1'b0), .trap_exit(1'b0), .div_by_zero(1'b0), .shift_too_far(1'b0),
    .acc_ovf31(1'b0), .guard_bits_used(1'b0), .acc_ovf39(1'b0), .saturation_on(1'b0),
    .misaligned_access(1'b0), .unimpl_data_access(1'b0), .unimpl_prog_access(1'b0),
    .vector_space_fetch(1'b0), .mac_x_hits_y(1'b0), .mac_y_hits_x(1'b0),
    .invalid_vector_addr(1'b0), .literal_jump_unimpl(1'b0), .pc_exec_unimpl(1'b0),
    .div_abort(), .trap_req(), .trap_vector(), .trap_level(), .trap_level_top_bit(),
    .wdt_timeout(1'b0), .uninit_w_pointer(1'b0), .illegal_opcode_exec(1'b0),
    .insn_flushed(1'b0), .brownout_reset(1'b0), .reset_req(), .reset_vector_addr()
  );

  // ***********************************************
  // Shared tasks
  // ***********************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic close_out;
    if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : apb

  task automatic setp(input int s, input logic [2:0] p);
    logic [31:0] w;
    int b;
    w = 32'h0;
    b = (s / 4) * 4;
    pr[s] = p;
    for (int k = 0; k < 4; k++) w[4 * k +: 3] = pr[b + k];
    apb(1'b1, 12'(b), w);
  endtask : setp

  task automatic irq_chk(input logic [53:0] p, input logic [3:0] l, input logic q,
                         input logic [5:0] v, input logic [2:0] il);
    irq_pending <= p;
    base_level <= l;
    repeat (2) @(posedge ref_clk);
    chk(irq_req, q);
    if (q) begin
      chk(irq_vector, v);
      chk(irq_level, il);
    end
  endtask : irq_chk

  task automatic trap_case(input logic [12:0] m, input logic ex, input logic [5:0] v,
                           input logic [3:0] l);
    int n;
    n = 0;
    det <= m;
    @(posedge ref_clk);
    chk(div_abort, m[0]);
    det <= 13'h0;
    while (trap_req !== 1'b1 && n < 8) begin
      @(posedge ref_clk);
      n++;
    end
    chk(trap_req, ex);
    if (ex) begin
      chk(trap_vector, v);
      chk(trap_level, l);
      n = 0;
      while (trap_level_top_bit !== 1'b1 && n < 8) begin
        @(posedge ref_clk);
        n++;
      end
      chk(trap_level_top_bit, 1'b1);
      exit_go <= 1'b1;
      @(posedge ref_clk);
      exit_go <= 1'b0;
      repeat (2) @(posedge ref_clk);
      chk(trap_level_top_bit, 1'b0);
    end
  endtask : trap_case

  task automatic reset_case(input logic [4:0] m, input logic ex, input logic [4:0] cause);
    rc <= m;
    @(posedge ref_clk);
    rc <= 5'h0;
    @(posedge ref_clk);
    chk(reset_req, ex);
    apb(1'b0, intc_pkg::RST_CAUSE_ADDR, 32'h0);
    chk(rd, {27'h0, cause});
    apb(1'b1, intc_pkg::RST_CAUSE_ADDR, 32'h1F);
  endtask : reset_case

  // ***********************************************
  // Scenarios
  // ***********************************************
  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h4444);
    apb(1'b0, 12'h034, 32'h0);
    chk(rd, 32'h0044);
    apb(1'b1, 12'h004, 32'hFFFFFFFF);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h7777);
    for (int k = 4; k < 8; k++) pr[k] = 3'h7;
    apb(1'b0, 12'h03C, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b0, intc_pkg::CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
  endtask : t_regs

  task automatic t_irq;
    for (int n = 0; n < 54; n++) begin
      irq_chk(54'h1 << n, 4'h0, intc_pkg::SRC_IMPL_MASK[n], 6'(n + 8), pr[n]);
      chk(irq_req_b, intc_pkg::SRC_IMPL_MASK[n] & ~intc_pkg::UART_B_MASK[n]);
    end
    setp(3, 3'h5);
    setp(5, 3'h5);
    irq_chk(54'h28, 4'h2, 1'b1, 6'h0B, 3'h5);
    setp(5, 3'h6);
    irq_chk(54'h28, 4'h2, 1'b1, 6'h0D, 3'h6);
    irq_chk(54'h28, 4'h6, 1'b0, 6'h0, 3'h0);
    irq_chk(54'h28, 4'h5, 1'b1, 6'h0D, 3'h6);
    apb(1'b0, intc_pkg::SEL_STAT_ADDR, 32'h0);
    chk(rd, 32'h0000_038D);
    setp(5, 3'h0);
    irq_chk(54'h20, 4'h0, 1'b0, 6'h0, 3'h0);
    setp(3, 3'h7);
    irq_chk(54'h8, 4'h7, 1'b0, 6'h0, 3'h0);
    irq_chk(54'h0, 4'h0, 1'b0, 6'h0, 3'h0);
  endtask : t_irq

  task automatic t_trap;
    base_level <= 4'h7;
    apb(1'b1, intc_pkg::CTRL_ADDR, 32'h3);
    trap_case(13'h1, 1'b1, intc_pkg::MATH_TRAP_VEC, intc_pkg::MATH_TRAP_LEVEL);
    trap_case(13'h2, 1'b1, intc_pkg::MATH_TRAP_VEC, intc_pkg::MATH_TRAP_LEVEL);
    trap_case(13'h4, 1'b1, intc_pkg::MATH_TRAP_VEC, intc_pkg::MATH_TRAP_LEVEL);
    guard <= 1'b1;
    trap_case(13'h4, 1'b0, 6'h0, 4'h0);
    guard <= 1'b0;
    trap_case(13'h8, 1'b1, intc_pkg::MATH_TRAP_VEC, intc_pkg::MATH_TRAP_LEVEL);
    sat <= 1'b1;
    trap_case(13'h8, 1'b0, 6'h0, 4'h0);
    sat <= 1'b0;
    ack_wait <= 4'h3;
    for (int b = 4; b < 13; b++) begin
      trap_case(13'h1 << b, 1'b1, intc_pkg::ADDR_TRAP_VEC, intc_pkg::ADDR_TRAP_LEVEL);
    end
    stall <= 1'b1;
    det <= 13'h10;
    @(posedge ref_clk);
    det <= 13'h0;
    repeat (4) @(posedge ref_clk);
    chk(trap_req, 1'b0);
    apb(1'b0, intc_pkg::TRAP_STAT_ADDR, 32'h0);
    chk(rd, 32'h2);
    stall <= 1'b0;
    trap_case(13'h0, 1'b1, intc_pkg::ADDR_TRAP_VEC, intc_pkg::ADDR_TRAP_LEVEL);
  endtask : t_trap

  task automatic t_reset;
    chk(reset_vector_addr, 32'h0);
    reset_case(5'h01, 1'b1, 5'h01);
    reset_case(5'h02, 1'b1, 5'h02);
    reset_case(5'h04, 1'b1, 5'h04);
    reset_case(5'h10, 1'b1, 5'h08);
    reset_case(5'h0C, 1'b0, 5'h00);
    det <= 13'h11;
    @(posedge ref_clk);
    det <= 13'h0;
    @(posedge ref_clk);
    chk(reset_req, 1'b1);
    repeat (6) @(posedge ref_clk);
    chk(trap_req, 1'b0);
    apb(1'b0, intc_pkg::RST_CAUSE_ADDR, 32'h0);
    chk(rd, 32'h10);
  endtask : t_reset

  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    t_regs();
    t_irq();
    t_trap();
    t_reset();
    close_out();
  end
endmodule : interrupt_trap_priority_resolver_tb_top
`default_nettype wire
